// ---- rtl/arc_pkg.sv ----
// Constants of the converter register interface.
// Assumes an 8-bit register port on the 25 MHz CPU clock.
//
// Notes on behaviour
// - Done flag sets on completion; clears on result_high read or any status write.
// - Done flag at bit 7 is read-only; other status bits read and write.
// - Reset loads zero into all three registers.
// - Status bit 6 is the fast clock select, combined with quarter select.
// - Low register bit 3 is quarter select; clock is full, half or quarter.
// - Status bit 5 switches the converter on when one.
// - Status bits 2 to 0 select analog input 0 to 7 in binary.
// - result_high reads result bits 9 down to 2.
// - Low register bits 1 and 0 read result bits 1 and 0.
// - Low register bits 7 to 4 and 2 always read zero.
// - Registers decode at 34h, 35h and 36h.
// - While on, the selected channel converts continuously, each result setting done.
// - A channel change aborts the conversion, clears done and restarts; one landing in the start cycle aborts with no restart.
package arc_pkg;
	localparam int          ADDR_W        = 16;
	localparam logic [15:0] ADDR_CSR      = 16'h0034;
	localparam logic [15:0] ADDR_RES_HIGH = 16'h0035;
	localparam logic [15:0] ADDR_RES_LOW  = 16'h0036;
	localparam logic [15:0] ADDR_IRQ_STAT = 16'h0037;
	localparam logic [15:0] ADDR_IRQ_EN   = 16'h0038;
	localparam logic [15:0] ADDR_IRQ_CLR  = 16'h0039;
	localparam int          CSR_DONE      = 7;
	localparam int          CSR_FAST      = 6;
	localparam int          CSR_ON        = 5;
	localparam int          CSR_CH_LSB    = 0;
	localparam int          CH_W          = 3;
	localparam int          LOW_QUARTER   = 3;
	localparam logic [7:0]  CSR_RESET     = 8'h00;
	localparam logic [7:0]  CSR_WMASK     = 8'h7f;
	localparam logic [9:0]  RESULT_RESET  = 10'h000;
	localparam int          IRQ_W         = 2;
	localparam int          IRQ_DONE      = 0;
	localparam int          IRQ_ABORT     = 1;
	localparam logic [1:0]  DIV_FULL      = 2'h0;
	localparam logic [1:0]  DIV_HALF      = 2'h1;
	localparam logic [1:0]  DIV_QUARTER   = 2'h2;
	typedef enum logic [1:0]
	{
		ARC_IDLE  = 2'b00,
		ARC_START = 2'b01,
		ARC_BUSY  = 2'b10
	} arc_state_t;
endpackage

// ---- rtl/arc_clkdiv.sv ----
// Converter clock enable: full, half or quarter of the CPU clock.
// Assumes the select is steady over a conversion; a change keeps the running phase.
`timescale 1ns/1ps
`default_nettype none
module arc_clkdiv
	import arc_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Control
	input  wire logic       run,
	input  wire logic [1:0] div_sel,
	// Converter tick
	output logic            tick
);
	logic [1:0] phase;

	always_ff @(posedge clk)
	begin
		if (rst || !run)
			phase <= 2'h0;
		else
			phase <= phase + 2'h1;
	end

	always_comb
	begin
		case (div_sel)
			DIV_FULL:    tick = run;
			DIV_HALF:    tick = run && phase[0];
			default:     tick = run && (phase == 2'h3);
		endcase
	end
endmodule
`default_nettype wire

// ---- rtl/arc_irq.sv ----
// Sticky event status with enable and write-one-to-clear.
// Set wins over a clear landing in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module arc_irq
	import arc_pkg::*;
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Events and software access
	input  wire logic [IRQ_W-1:0] event_in,
	input  wire logic [IRQ_W-1:0] clear,
	input  wire logic             en_write,
	input  wire logic [IRQ_W-1:0] en_data,
	// State
	output logic      [IRQ_W-1:0] status,
	output logic      [IRQ_W-1:0] enable,
	output logic                  irq
);
	genvar i;
	generate
		for (i = 0; i < IRQ_W; i++)
		begin : g_bit
			always_ff @(posedge clk)
			begin
				if (rst)
					status[i] <= 1'b0;
				else if (event_in[i])
					status[i] <= 1'b1;
				else if (clear[i])
					status[i] <= 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (rst)
			enable <= '0;
		else if (en_write)
			enable <= en_data;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= |(status & enable);
	end
endmodule
`default_nettype wire

// ---- rtl/arc_top.sv ----
// Converter register interface and conversion sequencing.
// Assumes a same-clock register port and a synchronous analog core
// that answers a start request with a one-cycle done strobe.
`timescale 1ns/1ps
`default_nettype none
module arc_top
	import arc_pkg::*;
(
	// Clock and reset
	input  wire logic              CLOCK,
	input  wire logic              SYS_RST,
	// Register port
	input  wire logic [ADDR_W-1:0] ADDR,
	input  wire logic [7:0]        WDATA,
	input  wire logic              WR,
	input  wire logic              RD,
	output logic      [7:0]        RDATA,
	// Analog core
	output logic                   CONV_START,
	output logic                   CONV_ABORT,
	output logic      [CH_W-1:0]   CONV_CHANNEL,
	output logic                   CONV_POWER,
	output logic                   CONV_TICK,
	input  wire logic              CONV_DONE,
	input  wire logic [9:0]        CONV_RESULT,
	// Interrupt
	output logic                   IRQ
);
	logic [7:0]       csr;
	logic             quarter;
	logic [9:0]       result;
	arc_state_t       state;
	arc_state_t       next_state;
	logic             wr_csr;
	logic             rd_high;
	logic             ch_change;
	logic             done_evt;
	logic             tick;
	logic [1:0]       div_sel;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_enable;
	logic             irq_int;

	// Address decode
	assign wr_csr    = WR && (ADDR == ADDR_CSR);
	assign rd_high   = RD && (ADDR == ADDR_RES_HIGH);
	assign ch_change = wr_csr && csr[CSR_ON]
		&& (WDATA[CH_W-1:0] != csr[CH_W-1:0]);
	// A done strobe outside a live conversion or under abort is stale
	assign done_evt  = CONV_DONE && (state == ARC_BUSY) && csr[CSR_ON] && !ch_change
		&& !(wr_csr && !WDATA[CSR_ON]);

	// Writable control bits; done flag kept apart
	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
			csr[6:0] <= CSR_RESET[6:0];
		else if (wr_csr)
			csr[6:0] <= WDATA[6:0] & CSR_WMASK[6:0];
	end

	// Done flag: completion wins over a same-cycle clear
	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
			csr[CSR_DONE] <= 1'b0;
		else if (done_evt)
			csr[CSR_DONE] <= 1'b1;
		else if (wr_csr || rd_high)
			csr[CSR_DONE] <= 1'b0;
	end

	// Quarter select in the low data register
	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
			quarter <= 1'b0;
		else if (WR && (ADDR == ADDR_RES_LOW))
			quarter <= WDATA[LOW_QUARTER];
	end

	// Result capture on the core's strobe
	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
			result <= RESULT_RESET;
		else if (done_evt)
			result <= CONV_RESULT;
	end

	// Clock rate: quarter overrides fast
	always_comb
	begin
		if (quarter)
			div_sel = DIV_QUARTER;
		else if (csr[CSR_FAST])
			div_sel = DIV_FULL;
		else
			div_sel = DIV_HALF;
	end

	arc_clkdiv u_div
	(
		.clk     (CLOCK),
		.rst     (SYS_RST),
		.run     (csr[CSR_ON]),
		.div_sel (div_sel),
		.tick    (tick)
	);

	// Continuous conversion sequencer
	always_comb
	begin
		next_state = state;
		case (state)
			ARC_IDLE:
				if (csr[CSR_ON])
					next_state = ARC_START;
			ARC_START:
				next_state = ARC_BUSY;
			ARC_BUSY:
				if (CONV_DONE || ch_change)
					next_state = ARC_START;
			default:
				next_state = ARC_IDLE;
		endcase
		if (!csr[CSR_ON] || (wr_csr && !WDATA[CSR_ON]))
			next_state = ARC_IDLE;
	end

	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
			state <= ARC_IDLE;
		else
			state <= next_state;
	end

	// Core strobes are registered so the outputs come from flip-flops
	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
		begin
			CONV_START <= 1'b0;
			CONV_ABORT <= 1'b0;
		end
		else
		begin
			CONV_START <= (next_state == ARC_START);
			CONV_ABORT <= ch_change && (state != ARC_IDLE);
		end
	end

	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
		begin
			CONV_CHANNEL <= '0;
			CONV_POWER   <= 1'b0;
			CONV_TICK    <= 1'b0;
		end
		else
		begin
			CONV_CHANNEL <= csr[CH_W-1:0];
			CONV_POWER   <= csr[CSR_ON];
			CONV_TICK    <= tick;
		end
	end

	// Read data one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
			RDATA <= 8'h00;
		else if (RD)
		begin
			case (ADDR)
				ADDR_CSR:      RDATA <= csr;
				ADDR_RES_HIGH: RDATA <= result[9:2];
				ADDR_RES_LOW:  RDATA <= {4'h0, quarter, 1'b0, result[1:0]};
				ADDR_IRQ_STAT: RDATA <= {6'h00, irq_status};
				ADDR_IRQ_EN:   RDATA <= {6'h00, irq_enable};
				default:       RDATA <= 8'h00;
			endcase
		end
		else
			RDATA <= 8'h00;
	end

	arc_irq u_irq
	(
		.clk      (CLOCK),
		.rst      (SYS_RST),
		.event_in ({ch_change && (state != ARC_IDLE), done_evt}),
		.clear    ((WR && (ADDR == ADDR_IRQ_CLR)) ? WDATA[IRQ_W-1:0] : '0),
		.en_write (WR && (ADDR == ADDR_IRQ_EN)),
		.en_data  (WDATA[IRQ_W-1:0]),
		.status   (irq_status),
		.enable   (irq_enable),
		.irq      (irq_int)
	);

	assign IRQ = irq_int;
endmodule
`default_nettype wire

// ---- tb/arc_props.sv ----
// Port checker of the converter register interface.
// Bound onto arc_top by the bench; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module arc_props
	import arc_pkg::*;
(
	// Clock and reset
	input wire logic              CLOCK,
	input wire logic              SYS_RST,
	// Register port
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic [7:0]        WDATA,
	input wire logic              WR,
	input wire logic              RD,
	input wire logic [7:0]        RDATA,
	// Core side
	input wire logic              CONV_START,
	input wire logic              CONV_ABORT,
	input wire logic [CH_W-1:0]   CONV_CHANNEL,
	input wire logic              CONV_POWER,
	input wire logic              CONV_TICK,
	input wire logic              IRQ
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);
	a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
		else $error("read data outside read cycle");
	a_low_zero: assert property (RD && ADDR == ADDR_RES_LOW |=> RDATA[7:4] == 4'h0 && !RDATA[2])
		else $error("low register zero bits set");
	a_unmapped_read: assert property (RD && ADDR > ADDR_IRQ_CLR |=> RDATA == 8'h00)
		else $error("unmapped read not zero");
	a_csr_mirror: assert property (RD && ADDR == ADDR_CSR && !$past(WR) |=> RDATA[2:0] == $past(CONV_CHANNEL))
		else $error("channel readback differs");
	a_chan_follow: assert property (WR && ADDR == ADDR_CSR |-> ##2 CONV_CHANNEL == $past(WDATA[2:0], 2))
		else $error("channel not applied");
	a_start_pulse: assert property (CONV_START |=> !CONV_START)
		else $error("start longer than one cycle");
	a_start_power: assert property (CONV_START |-> CONV_POWER)
		else $error("start while off");
	a_abort_cause: assert property (CONV_ABORT |-> $past(WR) || $past(WR, 2))
		else $error("abort without write");
	a_tick_off: assert property (!CONV_POWER && !$past(CONV_POWER) |-> !CONV_TICK)
		else $error("tick while off");
	c_start: cover property (CONV_START);
	c_abort: cover property (CONV_ABORT);
	c_irq: cover property ($rose(IRQ));
endmodule
`default_nettype wire

// ---- tb/arc_tb_top.sv ----
// Self-checking bench of the converter register interface.
// Drives the register port and stands in for the analog core.
`timescale 1ns/1ps
`default_nettype none
module arc_tb_top
	import arc_pkg::*;
;
	logic              CLOCK = 0, SYS_RST = 1, WR = 0, RD = 0, CONV_DONE = 0;
	logic [ADDR_W-1:0] ADDR = '0;
	logic [7:0]        WDATA = 8'h00, RDATA;
	logic [9:0]        CONV_RESULT = 10'h000;
	logic              CONV_START, CONV_ABORT, CONV_POWER, CONV_TICK, IRQ;
	logic [CH_W-1:0]   CONV_CHANNEL;
	int                num_errors = 0, n_checks = 0, cyc = 0, i, n;
	arc_top uut(.CLOCK(CLOCK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .CONV_START(CONV_START), .CONV_ABORT(CONV_ABORT), .CONV_CHANNEL(CONV_CHANNEL),
		.CONV_POWER(CONV_POWER), .CONV_TICK(CONV_TICK), .CONV_DONE(CONV_DONE),
		.CONV_RESULT(CONV_RESULT), .IRQ(IRQ));
	initial forever #20 CLOCK = ~CLOCK;
	task automatic end_of_test;
		if (num_errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge CLOCK)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			num_errors++;
			end_of_test;
		end
	end
	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		n_checks++;
		if (s !== e)
		begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge CLOCK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLOCK);
		WR <= 1'b0;
	endtask
	task automatic rc(input logic [15:0] a, input logic [7:0] e, input string nm);
		@(posedge CLOCK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLOCK);
		RD <= 1'b0;
		#1 chk(nm, RDATA, e);
	endtask
	// Waits for a start if w, answers it, expects the restart a cycle later
	task automatic fin(input logic [9:0] r, input logic w);
		n = 0;
		while (w && CONV_START !== 1'b1 && n < 40)
		begin
			@(posedge CLOCK);
			#1 n++;
		end
		if (w)
			chk("start", CONV_START, 1'b1);
		@(posedge CLOCK);
		CONV_DONE <= 1'b1;
		CONV_RESULT <= r;
		@(posedge CLOCK);
		CONV_DONE <= 1'b0;
		CONV_RESULT <= ~r;
		#1 chk("restart", CONV_START, 1'b1);
	endtask
	task automatic irq_is(input logic e);
		repeat (2) @(posedge CLOCK);
		#1 chk("irq", IRQ, e);
	endtask
	initial
	begin
		repeat (5) @(posedge CLOCK);
		SYS_RST <= 1'b0;
		rc(ADDR_CSR, 8'h00, "csr rst");
		rc(ADDR_RES_HIGH, 8'h00, "high rst");
		rc(ADDR_RES_LOW, 8'h00, "low rst");
		rc(16'h0040, 8'h00, "unmapped");
		wr(ADDR_RES_LOW, 8'hff);
		rc(ADDR_RES_LOW, 8'h08, "low mask");
		wr(ADDR_RES_HIGH, 8'h5a);
		rc(ADDR_RES_HIGH, 8'h00, "high ro");
		wr(ADDR_CSR, 8'hc6);
		rc(ADDR_CSR, 8'h46, "csr rw");
		// Full, half, quarter rate: ticks in 16 cycles
		for (i = 0; i < 3; i++)
		begin
			wr(ADDR_RES_LOW, i == 2 ? 8'h08 : 8'h00);
			wr(ADDR_CSR, i == 1 ? 8'h20 : 8'h60);
			repeat (4) @(posedge CLOCK);
			n = 0;
			repeat (16)
			begin
				@(posedge CLOCK);
				#1 n += (CONV_TICK === 1'b1);
			end
			chk("ticks", n, 16 >> i);
		end
		wr(ADDR_CSR, 8'h00);
		repeat (2) @(posedge CLOCK);
		#1 chk("power off", CONV_POWER, 1'b0);
		wr(ADDR_CSR, 8'h26);
		fin(10'h2a5, 1'b1);
		rc(ADDR_CSR, 8'ha6, "done set");
		rc(ADDR_RES_LOW, 8'h09, "low res");
		rc(ADDR_RES_HIGH, 8'ha9, "high res");
		rc(ADDR_CSR, 8'h26, "done rd clr");
		// Done event is sticky but masked until enabled
		rc(ADDR_IRQ_STAT, 8'h01, "irq stat");
		irq_is(1'b0);
		wr(ADDR_IRQ_EN, 8'h01);
		irq_is(1'b1);
		wr(ADDR_IRQ_CLR, 8'h01);
		irq_is(1'b0);
		// Channel change in mid conversion restarts at once
		wr(ADDR_CSR, 8'h22);
		n = 0;
		i = 0;
		repeat (3)
		begin
			#1 n += (CONV_ABORT === 1'b1);
			i += (CONV_START === 1'b1);
			@(posedge CLOCK);
		end
		chk("abort", n, 1);
		chk("abort restart", i, 1);
		chk("channel", CONV_CHANNEL, 3'h2);
		chk("power on", CONV_POWER, 1'b1);
		rc(ADDR_IRQ_STAT, 8'h02, "abort stat");
		// Conversion already running since the restart
		fin(10'h1ff, 1'b0);
		rc(ADDR_CSR, 8'ha2, "new chan done");
		wr(ADDR_CSR, 8'h22);
		rc(ADDR_CSR, 8'h22, "done wr clr");
		end_of_test;
	end
endmodule
bind arc_top arc_props u_props(.CLOCK(CLOCK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
	.RD(RD), .RDATA(RDATA), .CONV_START(CONV_START), .CONV_ABORT(CONV_ABORT),
	.CONV_CHANNEL(CONV_CHANNEL), .CONV_POWER(CONV_POWER), .CONV_TICK(CONV_TICK), .IRQ(IRQ));
`default_nettype wire
